// *** verilog/fsc_pkg.sv ***
// constants and types shared by the frequency sweep controller
package fsc_pkg;

    // ========================================================
    // register byte offsets
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_BEG_LO = 8'h08;
    localparam logic [7:0] OFF_BEG_HI = 8'h0c;
    localparam logic [7:0] OFF_END_LO = 8'h10;
    localparam logic [7:0] OFF_END_HI = 8'h14;
    localparam logic [7:0] OFF_MKR_LO = 8'h18;
    localparam logic [7:0] OFF_MKR_HI = 8'h1c;
    localparam logic [7:0] OFF_TIME   = 8'h20;
    localparam logic [7:0] OFF_CUR_LO = 8'h24;
    localparam logic [7:0] OFF_CUR_HI = 8'h28;

    // ========================================================
    // control register fields (bits 2..6 are write-one commands)
    localparam int B_LOG   = 0;
    localparam int B_DISC  = 1;
    localparam int B_CONT  = 2;
    localparam int B_RS    = 3;
    localparam int B_CTR   = 4;
    localparam int B_STORE = 5;
    localparam int B_CLR   = 6;
    localparam int B_SIDX  = 8;

    // status register fields
    localparam int S_SGL  = 0;
    localparam int S_CONT = 1;
    localparam int S_ARM  = 2;
    localparam int S_DOWN = 3;
    localparam int S_MKR  = 4;
    localparam int S_ERR  = 5;
    localparam int S_SEG  = 8;

    // ========================================================
    // reset values, frequencies in micro-hertz, time in ms
    localparam logic [47:0] BEG_RST  = 48'h00e8_d4a5_1000;
    localparam logic [47:0] END_RST  = 48'h0918_4e72_a000;
    localparam logic [47:0] MKR_RST  = 48'h048c_2739_5000;
    localparam logic [19:0] TIME_RST = 20'h003e8;

    // ========================================================
    // limits and timing
    localparam logic [19:0] T_MIN_LIN   = 20'h0000a;
    localparam logic [19:0] T_MIN_LOG_S = 20'h003e8;
    localparam logic [19:0] T_MIN_LOG_C = 20'h00064;
    localparam logic [19:0] T_MAX       = 20'hf4240;
    localparam logic [19:0] T_RAMP_LIM  = 20'h186a0;
    localparam logic [19:0] T_FINE_LIM  = 20'h003e8;
    localparam logic [47:0] F_FINE_LIM  = 48'h0017_4876_e800;
    localparam int CLK_NS       = 4;
    localparam int TICK_NS      = 1000;
    localparam int TICK_CYC_DEF = TICK_NS / CLK_NS;
    localparam int TICKS_PER_MS = 1000000 / TICK_NS;
    localparam int MKR_US       = 400;
    localparam int MKR_TICKS    = MKR_US * 1000 / TICK_NS;

    // ========================================================
    // sweep parameter set
    typedef struct packed {
        logic [47:0] fbeg;
        logic [47:0] fend;
        logic [47:0] fmkr;
        logic [19:0] tms;
    } fsc_par_type;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_DIV  = 3'b010,
        ST_RUN  = 3'b100
    } fsc_state_type;

endpackage

// *** verilog/fsc_sweep.sv ***
// frequency sweep sequencer with apb register access
//
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/100ps
module fsc_sweep #(
    parameter int NSEG     = 100,
    parameter int TICK_CYC = fsc_pkg::TICK_CYC_DEF
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // frequency word to the synthesis core, micro-hertz
    output logic      [47:0] freq_word,
    // rear outputs
    output logic             marker_n,
    output logic      [11:0] ramp,
    output logic             ramp_on,
    // front indicators
    output logic             single_ind,
    output logic             cont_ind
);
    import fsc_pkg::*;

    // ========================================================
    // elaboration checks
    if (NSEG < 1 || NSEG > 128) begin : g_chk_seg
        $error("NSEG must be 1..128");
    end
    if (TICK_CYC < 2 || TICK_CYC > 65535) begin : g_chk_tick
        $error("TICK_CYC must be 2..65535");
    end

    // ========================================================
    // helpers
    // index of highest set bit
    function automatic logic [5:0] msb(input logic [47:0] v);
        logic [5:0] r;
        r = 6'h00;
        for (int i = 0; i < 48; i++) begin
            if (v[i]) r = 6'(i);
        end
        return r;
    endfunction

    // first valid segment at or above from, {found, index}
    function automatic logic [7:0] fnext(input logic [NSEG-1:0] v, input logic [7:0] from);
        logic [7:0] r;
        r = 8'h00;
        for (int i = NSEG - 1; i >= 0; i--) begin
            if (v[i] && 8'(i) >= from) r = {1'b1, 7'(i)};
        end
        return r;
    endfunction

    function automatic fsc_par_type eff(input fsc_par_type p, input logic lg, input logic ct);
        fsc_par_type r;
        logic [19:0] mn;
        r  = p;
        mn = lg ? (ct ? T_MIN_LOG_C : T_MIN_LOG_S) : T_MIN_LIN;
        if (r.tms < mn) r.tms = mn;
        if (r.tms > T_MAX) r.tms = T_MAX;
        return r;
    endfunction

    // held frequency resolution: whole milli-hertz above the fine limit
    function automatic logic [47:0] qfreq(input logic [47:0] f);
        return (f > F_FINE_LIM) ? f - (f % 48'd1000) : f;
    endfunction

    // held time resolution: 10 ms steps at and above one second
    function automatic logic [19:0] qtime(input logic [19:0] t);
        return (t >= T_FINE_LIM) ? t - (t % 20'd10) : t;
    endfunction

    function automatic logic [29:0] ticks(input logic [19:0] t);
        return 30'(t * TICKS_PER_MS);
    endfunction

    function automatic logic [47:0] fbw(input fsc_par_type p);
        return (p.fend >= p.fbeg) ? p.fend - p.fbeg : p.fbeg - p.fend;
    endfunction

    // ========================================================
    // state
    fsc_state_type   state_q;
    fsc_par_type     par_q, act_q;
    fsc_par_type     seg_q [NSEG];
    logic [NSEG-1:0] segv_q;
    logic            log_q, disc_q;
    logic [6:0]      sidx_q, segi_q;
    logic            cont_q, armed_q, up_q, pass_q, mark_q, err_q, raise_q;
    logic [30:0]     rem_q;
    logic [47:0]     quo_q, inc_q, cur_q;
    logic [29:0]     dsr_q, left_q;
    logic [5:0]      dcnt_q;
    logic [31:0]     rinc_q, racc_q;
    logic [15:0]     tdiv_q;

    // ========================================================
    // apb decode
    logic acc, wr, cmd_rs, cmd_cc, cmd_ctr, wr_ctrl, run, lg;
    assign acc     = psel && penable && pready;
    assign wr      = acc && pwrite;
    assign wr_ctrl = wr && paddr == OFF_CTRL;
    assign cmd_rs  = wr_ctrl && pwdata[B_RS];
    assign cmd_cc  = wr_ctrl && pwdata[B_CONT];
    assign cmd_ctr = wr_ctrl && pwdata[B_CTR];
    assign run     = state_q != ST_IDLE;
    // mode decode, discrete takes precedence over log
    assign lg      = log_q && !disc_q;

    // ========================================================
    // load of the next parameter set
    logic [7:0]  f0, f1, ld_idx;
    fsc_par_type nxt;
    logic        tick, last, ok, stop, load;
    assign f0     = fnext(segv_q, 8'h00);
    assign f1     = fnext(segv_q, 8'({1'b0, segi_q} + 8'h01));
    assign ld_idx = (run && f1[7]) ? f1 : f0;
    assign nxt    = disc_q ? eff(seg_q[ld_idx[6:0]], 1'b0, 1'b0) : eff(par_q, lg, cmd_cc);
    assign tick   = state_q == ST_RUN && tdiv_q == 16'(TICK_CYC - 1);
    assign last   = tick && left_q <= 30'h1;
    // a log sweep needs end above begin; discrete needs a segment
    assign ok     = disc_q ? f0[7] : (!lg || par_q.fbeg < par_q.fend);
    assign stop   = run && (cmd_rs || (cmd_cc && cont_q));
    assign load   = (state_q == ST_IDLE && ok && ((cmd_rs && armed_q) || cmd_cc))
                  || (last && disc_q && !stop && (f1[7] || cont_q));

    // ========================================================
    // divider and step arithmetic
    logic [30:0] tr;
    logic        qb;
    logic [47:0] qn, mw, stp, nup, ndn;
    logic [5:0]  lsh;
    assign tr  = {rem_q[29:0], quo_q[47]};
    assign qb  = tr >= {1'b0, dsr_q};
    assign qn  = {quo_q[46:0], qb};
    // marker window: increment times the 400 us tick count
    assign mw  = 48'(inc_q * MKR_TICKS);
    assign lsh = (msb(cur_q) > msb(act_q.fbeg)) ? msb(cur_q) - msb(act_q.fbeg) : 6'h00;
    // log sweeps double the step each octave: segmented log curve
    assign stp = lg ? inc_q << lsh : inc_q;
    assign nup = (48'(cur_q + stp) > act_q.fend || 48'(cur_q + stp) < cur_q) ? act_q.fend : 48'(cur_q + stp);
    assign ndn = (stp > cur_q || cur_q - stp < act_q.fend) ? act_q.fend : cur_q - stp;

    // ========================================================
    // apb response, no wait state; read data comes from a flop loaded in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (psel && !penable) begin
            pready  <= 1'b1;
            pslverr <= paddr > OFF_CUR_HI || paddr[1:0] != 2'b00;
            unique case (paddr)
                OFF_CTRL:   prdata <= {17'h0, sidx_q, 6'h0, disc_q, log_q};
                OFF_STATUS: prdata <= {17'h0, segi_q, 2'h0, err_q, mark_q,
                                       !up_q, armed_q, run && cont_q, run && !cont_q};
                OFF_BEG_LO: prdata <= par_q.fbeg[31:0];
                OFF_BEG_HI: prdata <= {16'h0, par_q.fbeg[47:32]};
                OFF_END_LO: prdata <= par_q.fend[31:0];
                OFF_END_HI: prdata <= {16'h0, par_q.fend[47:32]};
                OFF_MKR_LO: prdata <= par_q.fmkr[31:0];
                OFF_MKR_HI: prdata <= {16'h0, par_q.fmkr[47:32]};
                OFF_TIME:   prdata <= {12'h0, par_q.tms};
                OFF_CUR_LO: prdata <= cur_q[31:0];
                OFF_CUR_HI: prdata <= {16'h0, cur_q[47:32]};
                default:    prdata <= 32'h0000_0000;
            endcase
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // ========================================================
    // programmed parameters and mode selection
    // power-up values
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            par_q  <= '{fbeg: BEG_RST, fend: END_RST, fmkr: MKR_RST, tms: TIME_RST};
            log_q  <= 1'b0;
            disc_q <= 1'b0;
            sidx_q <= 7'h00;
        end else begin
            // low word write commits resolution
            // high half is taken raw: rounding it could borrow and corrupt it, so write high first
            if (wr && paddr == OFF_BEG_LO) par_q.fbeg <= qfreq({par_q.fbeg[47:32], pwdata});
            if (wr && paddr == OFF_BEG_HI) par_q.fbeg[47:32] <= pwdata[15:0];
            if (wr && paddr == OFF_END_LO) par_q.fend <= qfreq({par_q.fend[47:32], pwdata});
            if (wr && paddr == OFF_END_HI) par_q.fend[47:32] <= pwdata[15:0];
            if (wr && paddr == OFF_MKR_LO) par_q.fmkr <= qfreq({par_q.fmkr[47:32], pwdata});
            if (wr && paddr == OFF_MKR_HI) par_q.fmkr[47:32] <= pwdata[15:0];
            // time clipped to the maximum, stepped by range
            if (wr && paddr == OFF_TIME) begin
                par_q.tms <= qtime((pwdata[19:0] > T_MAX || pwdata[31:20] != 12'h0) ? T_MAX : pwdata[19:0]);
            end
            if (wr_ctrl) begin
                log_q  <= pwdata[B_LOG];
                disc_q <= pwdata[B_DISC];
                sidx_q <= pwdata[B_SIDX+:7];
            end
            // shift band onto the marker, width kept
            if (cmd_ctr && !run) begin
                par_q.fbeg <= par_q.fmkr - 48'($signed(par_q.fend - par_q.fbeg) >>> 1);
                par_q.fend <= par_q.fmkr - 48'($signed(par_q.fend - par_q.fbeg) >>> 1)
                            + (par_q.fend - par_q.fbeg);
            end
            if (raise_q) par_q.fend <= act_q.fend;
        end
    end

    // ========================================================
    // NSEG segments stored; array unreset, validity reset
    always_ff @(posedge pclk) begin
        if (wr_ctrl && pwdata[B_STORE] && 32'(pwdata[B_SIDX+:7]) < NSEG) begin
            seg_q[pwdata[B_SIDX+:7]] <= par_q;
        end
    end

    // store wins over clear in the same write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            segv_q <= '0;
        end else if (wr_ctrl) begin
            if (pwdata[B_CLR]) segv_q <= '0;
            if (pwdata[B_STORE] && 32'(pwdata[B_SIDX+:7]) < NSEG) segv_q[pwdata[B_SIDX+:7]] <= 1'b1;
        end
    end

    // ========================================================
    // sweep engine
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_IDLE;
            act_q   <= '{fbeg: BEG_RST, fend: END_RST, fmkr: MKR_RST, tms: TIME_RST};
            cur_q   <= BEG_RST;
            cont_q  <= 1'b0;
            armed_q <= 1'b0;
            up_q    <= 1'b1;
            pass_q  <= 1'b0;
            mark_q  <= 1'b0;
            err_q   <= 1'b0;
            raise_q <= 1'b0;
            rem_q   <= '0;
            quo_q   <= '0;
            inc_q   <= '0;
            dsr_q   <= '0;
            left_q  <= '0;
            dcnt_q  <= '0;
            rinc_q  <= '0;
            racc_q  <= '0;
            tdiv_q  <= '0;
            segi_q  <= '0;
        end else begin
            raise_q <= 1'b0;
            if (stop) begin
                // cancel, output stays at the present frequency
                state_q <= ST_IDLE;
                armed_q <= 1'b0;
                mark_q  <= 1'b0;
            end else if (load) begin
                // armed single or continuous start; continuous kept
                if (state_q == ST_IDLE) cont_q <= cmd_cc;
                act_q   <= nxt;
                segi_q  <= ld_idx[6:0];
                cur_q   <= nxt.fbeg;
                up_q    <= nxt.fend >= nxt.fbeg;
                quo_q   <= fbw(nxt);
                dsr_q   <= ticks(nxt.tms);
                rem_q   <= '0;
                dcnt_q  <= '0;
                pass_q  <= 1'b0;
                racc_q  <= '0;
                mark_q  <= 1'b0;
                armed_q <= 1'b0;
                err_q   <= 1'b0;
                state_q <= ST_DIV;
            end else begin
                unique case (state_q)
                    ST_IDLE: begin
                        if (cmd_rs && !ok) err_q <= 1'b1;
                        if (cmd_cc && !ok) err_q <= 1'b1;
                        // first press returns to the begin frequency
                        if (cmd_rs && !armed_q && ok) begin
                            cur_q   <= disc_q ? seg_q[f0[6:0]].fbeg : par_q.fbeg;
                            segi_q  <= f0[6:0];
                            armed_q <= 1'b1;
                            racc_q  <= '0;
                            mark_q  <= 1'b0;
                        end
                    end
                    ST_DIV: begin
                        // increment is bandwidth over tick count
                        rem_q  <= qb ? tr - {1'b0, dsr_q} : tr;
                        quo_q  <= qn;
                        dcnt_q <= dcnt_q + 6'h01;
                        if (dcnt_q == 6'd47 && !pass_q) begin
                            inc_q  <= qn;
                            quo_q  <= 48'h0001_0000_0000;
                            rem_q  <= '0;
                            dcnt_q <= '0;
                            pass_q <= 1'b1;
                        end else if (dcnt_q == 6'd47) begin
                            rinc_q  <= qn[31:0];
                            left_q  <= dsr_q;
                            tdiv_q  <= '0;
                            state_q <= ST_RUN;
                            // widen a marker too close to the end
                            if (!lg && up_q && act_q.fmkr >= act_q.fbeg && act_q.fmkr < act_q.fend
                                && act_q.fend - act_q.fmkr < mw) begin
                                act_q.fend <= act_q.fmkr + mw;
                                raise_q    <= !disc_q;
                            end
                        end
                    end
                    ST_RUN: begin
                        tdiv_q <= tick ? 16'h0000 : tdiv_q + 16'h0001;
                        if (last) begin
                            // direction ends exactly on the end frequency
                            cur_q  <= act_q.fend;
                            left_q <= ticks(act_q.tms);
                            mark_q <= 1'b0;
                            if (!cont_q || disc_q) begin
                                state_q <= ST_IDLE;
                            end else if (!lg) begin
                                act_q.fbeg <= act_q.fend;
                                act_q.fend <= act_q.fbeg;
                                up_q       <= !up_q;
                            end else begin
                                // continuous log repeats upward from begin
                                cur_q  <= act_q.fbeg;
                                racc_q <= '0;
                            end
                        end else if (tick) begin
                            // frequency word only; the core phase is never reset
                            // step toward the end in either direction
                            cur_q  <= up_q ? nup : ndn;
                            left_q <= left_q - 30'h1;
                            racc_q <= (cont_q && !up_q && !lg) ? racc_q - rinc_q : racc_q + rinc_q;
                            // marker on reaching the programmed frequency
                            // linear marker only sweeping up; discrete both ways
                            if (!lg && (disc_q || up_q)
                                && (up_q ? cur_q >= act_q.fmkr : cur_q <= act_q.fmkr)) begin
                                mark_q <= 1'b1;
                            end
                        end
                    end
                    default: state_q <= ST_IDLE;
                endcase
            end
        end
    end

    // ========================================================
    // registered outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            freq_word  <= BEG_RST;
            marker_n   <= 1'b1;
            ramp       <= 12'h000;
            ramp_on    <= 1'b1;
            single_ind <= 1'b0;
            cont_ind   <= 1'b0;
        end else begin
            freq_word  <= cur_q;
            marker_n   <= !(mark_q && run);
            // ramp driven only for short sweep times
            // idle follows the programmed time, a running sweep its own
            ramp_on    <= (run ? act_q.tms : par_q.tms) < T_RAMP_LIM;
            ramp       <= ((run ? act_q.tms : par_q.tms) < T_RAMP_LIM) ? racc_q[31:20] : 12'h000;
            // continuous indicator while repetitive sweep runs
            single_ind <= run && !cont_q;
            cont_ind   <= run && cont_q;
        end
    end

endmodule

// *** sim/fsc_sweep_asserts.sv ***
// port checker for the frequency sweep controller
`timescale 1ns/100ps
module fsc_sweep_asserts (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb slave side
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // sweep outputs
    input wire logic        marker_n,
    input wire logic [11:0] ramp,
    input wire logic        ramp_on,
    input wire logic        single_ind,
    input wire logic        cont_ind
);
    // ==================================================
    // bus decode helpers
    wire setup = psel && !penable;
    wire bad   = paddr > 8'h28 || paddr[1:0] != 2'b00;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // ==================================================
    // apb answer timing
    a_ready_setup: assert property (setup |=> pready) else $error("no answer after setup");
    a_ready_pulse: assert property (pready |=> !pready) else $error("ready held too long");
    a_err_unmapped: assert property (setup && bad |=> pslverr) else $error("unmapped access accepted");
    a_err_mapped: assert property (setup && !bad |=> !pslverr) else $error("mapped access refused");
    a_rdata_hold: assert property (!setup |=> $stable(prdata)) else $error("read data moved");
    // ==================================================
    // sweep output relations
    a_ramp_idle: assert property (!ramp_on |-> ramp == 12'h000) else $error("ramp active");
    a_ind_excl: assert property (!(single_ind && cont_ind)) else $error("both sweeps run");
    a_mkr_running: assert property (!marker_n |-> single_ind || cont_ind || $past(single_ind || cont_ind))
        else $error("marker outside a sweep");
    // main scenarios reached
    c_marker: cover property (!marker_n);
    c_cont: cover property (cont_ind);
    c_error: cover property (pslverr);
endmodule
bind fsc_sweep fsc_sweep_asserts chk (.pclk, .presetn, .psel, .penable, .paddr, .prdata, .pready,
    .pslverr, .marker_n, .ramp, .ramp_on, .single_ind, .cont_ind);

// *** sim/fsc_host.sv ***
// apb command source in place of the key handler
`timescale 1ns/100ps
module fsc_host (
    // clock
    input wire logic        pclk,
    // apb master side
    output logic            psel = 1'b0,
    output logic            penable = 1'b0,
    output logic            pwrite = 1'b0,
    output logic [7:0]      paddr = 8'h00,
    output logic [31:0]     pwdata = 32'h0,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr
);
    logic [31:0] rdat;
    logic        rerr;
    // one transfer; request held until ready is seen at an edge
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

// *** sim/fsc_sweep_tb.sv ***
// self-checking bench for the frequency sweep controller
`timescale 1ns/100ps
module fsc_sweep_tb;
    import fsc_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, marker_n, ramp_on, single_ind, cont_ind;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [47:0] freq_word, v, r;
    logic [11:0] ramp;
    int err_count = 0;
    int num_checks = 0;
    int mk_low = 0;
    int tt[4] = '{1234, 567, 100000, 10};
    int te[4] = '{1230, 567, 100000, 10};
    // clock and marker activity count
    always #2 pclk = ~pclk;
    always @(posedge pclk) if (!marker_n) mk_low++;
    fsc_sweep #(.TICK_CYC(2)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .freq_word, .marker_n, .ramp, .ramp_on, .single_ind, .cont_ind);
    fsc_host host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
    // ==================================================
    // compare, verdict and register helpers
    task chk(input logic [47:0] got, input logic [47:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task summarize;
        $display("checks=%0d errors=%0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // high word first so the final low write settles the quantization
    task wf(input logic [7:0] a, input logic [47:0] f);
        host.xfer(1'b1, a + 8'h04, {16'h0, f[47:32]});
        host.xfer(1'b1, a, f[31:0]);
    endtask
    task rdf(input logic [7:0] a);
        host.xfer(1'b0, a, 32'h0);
        v[31:0] = host.rdat;
        host.xfer(1'b0, a + 8'h04, 32'h0);
        v[47:32] = host.rdat[15:0];
    endtask
    function automatic logic [47:0] qf(input logic [47:0] f);
        return (f > F_FINE_LIM) ? f - f % 48'd1000 : f;
    endfunction
    // arm, start and wait for a single sweep to finish
    task sweep(input logic [47:0] b, input logic [47:0] e);
        wf(OFF_BEG_LO, b);
        wf(OFF_END_LO, e);
        host.xfer(1'b1, OFF_CTRL, 32'h8);
        repeat (4) @(posedge pclk);
        chk(freq_word, b);
        chk(single_ind, 1'b0);
        mk_low = 0;
        host.xfer(1'b1, OFF_CTRL, 32'h8);
        for (int i = 0; i < 8 && single_ind !== 1'b1; i++) @(posedge pclk);
        chk(single_ind, 1'b1);
        for (int i = 0; i < 30000 && single_ind !== 1'b0; i++) @(posedge pclk);
        chk(freq_word, e);
    endtask
    // ==================================================
    // main sequence
    initial begin
        void'($urandom(32'hbd86ade2));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk(freq_word, BEG_RST);
        chk({marker_n, ramp_on, single_ind, cont_ind}, 4'b1100);
        rdf(OFF_END_LO);
        chk(v, END_RST);
        host.xfer(1'b0, 8'h2c, 32'h0);
        chk(host.rerr, 1'b1);
        for (int i = 0; i < 6; i++) begin
            r = {(i[0] ? 16'h00e8 : 16'h0), $urandom};
            wf(OFF_MKR_LO, r);
            rdf(OFF_MKR_LO);
            chk(v, qf(r));
        end
        for (int i = 0; i < 4; i++) begin
            host.xfer(1'b1, OFF_TIME, tt[i]);
            host.xfer(1'b0, OFF_TIME, 32'h0);
            chk(host.rdat, te[i]);
            chk(ramp_on, tt[i] < 100000);
        end
        wf(OFF_BEG_LO, 48'd10000);
        wf(OFF_END_LO, 48'd50000);
        wf(OFF_MKR_LO, 48'd40000);
        host.xfer(1'b1, OFF_CTRL, 32'h10);
        rdf(OFF_BEG_LO);
        chk(v, 48'd20000);
        rdf(OFF_END_LO);
        chk(v, 48'd60000);
        sweep(48'd50000, 48'd10000);
        chk(mk_low, 0);
        host.xfer(1'b1, OFF_CTRL, 32'h1);
        host.xfer(1'b1, OFF_CTRL, 32'h9);
        host.xfer(1'b0, OFF_STATUS, 32'h0);
        chk({host.rdat[S_ERR], host.rdat[S_ARM], single_ind}, 3'b100);
        host.xfer(1'b1, OFF_CTRL, 32'h0);
        sweep(48'd10000, 48'd50000);
        chk(mk_low > 0, 1'b1);
        chk(ramp[11:8], 4'hf);
        host.xfer(1'b1, OFF_CTRL, 32'h4);
        // past the first turn, into the downward half
        repeat (20500) @(posedge pclk);
        mk_low = 0;
        repeat (3000) @(posedge pclk);
        chk(cont_ind, 1'b1);
        host.xfer(1'b0, OFF_STATUS, 32'h0);
        chk(host.rdat[S_DOWN], 1'b1);
        chk(mk_low, 0);
        host.xfer(1'b1, OFF_CTRL, 32'h8);
        repeat (4) @(posedge pclk);
        r = freq_word;
        repeat (50) @(posedge pclk);
        chk({cont_ind, freq_word}, {1'b0, r});
        summarize();
    end
    // hang guard well beyond the expected run
    initial begin
        repeat (90000) @(posedge pclk);
        err_count++;
        summarize();
    end
endmodule
